// >>> catr_pkg.sv
// Package with constants and types for the card answer-to-reset block
package catr_pkg;
  // ****************************************
  // Answer-to-reset bytes
  // ****************************************
  localparam logic [7:0] CATR_TS_DIRECT = 8'h3b; // Initial character, direct convention
  localparam logic [7:0] CATR_T0_BYTE = 8'h9a; // TA1 and TD1 present, ten historical bytes
  localparam logic [7:0] CATR_TA1_BYTE = 8'h96; // Advertised F=512, D=32 (covers D 8 and 16)
  localparam logic [7:0] CATR_TD1_BYTE = 8'h80; // TD2 follows, T=0
  localparam logic [7:0] CATR_TD2_BYTE = 8'h1f; // TA3 follows, T=15 global bytes
  localparam logic [7:0] CATR_TA3_BYTE = 8'hc7; // Clock stop and class indication
  localparam logic [7:0] CATR_CAT_IND = 8'h80; // Category indicator, compact TLV
  localparam logic [7:0] CATR_TAG_CDS = 8'h31; // Card data service tag, length 1
  localparam logic [7:0] CATR_CDS_VAL = 8'ha0; // Card data service value, arbitrary
  localparam logic [7:0] CATR_TAG_CCAP = 8'h73; // Card capabilities tag, length 3
  localparam logic [7:0] CATR_CCAP_VAL = 8'h21; // Card capabilities value, arbitrary
  localparam logic [7:0] CATR_ATR_LEN = 8'h11; // Total bytes including check byte
  localparam logic [7:0] CATR_PPSS = 8'hff; // PPS start byte
  // ****************************************
  // Factor codes
  // ****************************************
  localparam logic [3:0] CATR_FI_372 = 4'h1; // Fi code for 372
  localparam logic [3:0] CATR_FI_512 = 4'h9; // Fi code for 512
  localparam logic [3:0] CATR_DI_1 = 4'h1; // Di code for 1
  localparam logic [3:0] CATR_DI_8 = 4'h4; // Di code for 8
  localparam logic [3:0] CATR_DI_16 = 4'h5; // Di code for 16
  localparam logic CATR_TYPE2 = 1'b0; // Reaction type, 0 = type 1 (specific mode never kept)
  // Card phase
  typedef enum logic [2:0] {CATR_OFF, CATR_SEND_ATR, CATR_PPS_WAIT, CATR_PPS_RX, CATR_PPS_ECHO,
                            CATR_RUN} catr_state_type;
  // Byte of the answer at index i
  function automatic logic [7:0] catr_atr_byte(input logic [4:0] i);
    case (i)
      5'h00: catr_atr_byte = CATR_TS_DIRECT;
      5'h01: catr_atr_byte = CATR_T0_BYTE;
      5'h02: catr_atr_byte = CATR_TA1_BYTE;
      5'h03: catr_atr_byte = CATR_TD1_BYTE;
      5'h04: catr_atr_byte = CATR_TD2_BYTE;
      5'h05: catr_atr_byte = CATR_TA3_BYTE;
      5'h06: catr_atr_byte = CATR_CAT_IND;
      5'h07: catr_atr_byte = CATR_TAG_CDS;
      5'h08: catr_atr_byte = CATR_CDS_VAL;
      5'h09: catr_atr_byte = CATR_TAG_CCAP;
      5'h0a: catr_atr_byte = CATR_CCAP_VAL;
      5'h0b: catr_atr_byte = 8'h00;
      5'h0c: catr_atr_byte = 8'h00;
      5'h0d: catr_atr_byte = 8'h00;
      5'h0e: catr_atr_byte = 8'h00;
      5'h0f: catr_atr_byte = 8'h00;
      default: catr_atr_byte = 8'h00;
    endcase
  endfunction : catr_atr_byte
endpackage : catr_pkg

// >>> catr_pps_chk.sv
// Checker of a requested pair of factor codes against the supported set
`timescale 1ns/1ps
module catr_pps_chk
  import catr_pkg::*;
(
  input wire logic [3:0] fi_in, // Requested Fi code
  input wire logic [3:0] di_in, // Requested Di code
  output logic ok_out // Pair is supported
);
  // ****************************************
  // Supported pairs
  // ****************************************
  // Only the three pairs are accepted; others are refused so the card stays on defaults
  always_comb begin
    ok_out = ((fi_in == CATR_FI_372) && (di_in == CATR_DI_1)) || // R6
             ((fi_in == CATR_FI_512) && ((di_in == CATR_DI_8) || (di_in == CATR_DI_16))); // R9
  end
endmodule : catr_pps_chk

// >>> catr_top.sv
// Card-side answer-to-reset, reset-mode and PPS control
//
// Overview of operation
// R1 - Answer sent first after every reset
// R2 - Terminal accepts other interface and historical bytes
// R3 - Answer carries T=15 global interface bytes
// R4 - First historical byte is category 80
// R5 - Data objects tagged 31 then 73
// R6 - Support pairs 372/1, 512/8, 512/16
// R7 - First TA byte advertises F and D
// R8 - Non-default parameters only after PPS
// R9 - Terminal requests only advertised values
// R10 - First reset cold, later resets warm
// R11 - Cold reset: negotiable mode, security cleared
// R12 - Specific mode keeps protocol and factors
// R13 - Warm answers identical within one session
// R14 - Warm reset clears security status
// R15 - Selected flag on verify or command
// R16 - Terminal reads power need from responses
// R17 - Exactly one reaction type implemented
// R18 - Absent first TA means 372 and 1
// R19 - Session flag tracks contact activation
`timescale 1ns/1ps
module catr_top
  import catr_pkg::*;
(
  input wire logic sys_clk_in, // System clock 100 MHz
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic contact_act_in, // Contacts activated (level)
  input wire logic card_rst_pulse_in, // Terminal reset released (pulse)
  input wire logic rx_valid_in, // Received byte strobe
  input wire logic [7:0] rx_byte_in, // Received byte
  input wire logic tx_ready_in, // Transmitter takes a byte
  input wire logic access_ok_in, // Access condition verified (pulse)
  input wire logic app_cmd_in, // Application command executed (pulse)
  input wire logic no_access_cond_in, // Application needs no access condition
  input wire logic status_cmd_in, // Status command seen (pulse)
  input wire logic app_select_in, // Select command seen (pulse)
  output logic tx_valid_out, // Byte offered to transmitter
  output logic [7:0] tx_byte_out, // Byte to send
  output logic [3:0] fi_out, // Fi code in force
  output logic [3:0] di_out, // Di code in force
  output logic warm_out, // Last reset was warm
  output logic specific_out, // Specific mode
  output logic secure_out, // Security status set
  output logic selected_out, // Application counts as selected
  output logic atr_done_out // Answer finished, protocol may start
);
  catr_state_type state_r; // Card phase
  logic session_r; // Contacts active
  logic [4:0] idx_r; // Byte index in answer or PPS
  logic [7:0] chk_r; // Running check byte
  logic [7:0] pps_r [0:3]; // PPS bytes, index addressed
  logic pps_ok; // Requested pair supported
  logic [7:0] pps_pck; // XOR of received PPS bytes 0 to 2
  // ****************************************
  // Session and cold/warm distinction
  // ****************************************
  // Session set by a reset while contacts active; a reset seen inside a session is warm
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      session_r <= 1'b0;
      warm_out <= 1'b0;
    end else if (!contact_act_in) begin
      session_r <= 1'b0; // R19
      warm_out <= 1'b0;
    end else if (card_rst_pulse_in) begin
      warm_out <= session_r; // R10
      session_r <= 1'b1; // R19
    end
  end
  // ****************************************
  // Mode and factors
  // ****************************************
  // Type 1 behaviour is fixed, so warm resets also return to negotiable mode
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      specific_out <= 1'b0;
      fi_out <= CATR_FI_372;
      di_out <= CATR_DI_1;
    end else if (card_rst_pulse_in) begin
      specific_out <= session_r && CATR_TYPE2; // R17
      if (!(session_r && CATR_TYPE2)) begin
        fi_out <= CATR_FI_372; // R11
        di_out <= CATR_DI_1; // R18
      end // R12 keeps fi_out and di_out in specific mode
    end else if (state_r == CATR_PPS_ECHO && idx_r == 5'h03 && tx_ready_in && pps_ok && pps_pck == pps_r[3]) begin
      // Factors move only when the echo confirmed both the pair and the check byte
      fi_out <= pps_r[2][7:4]; // R8
      di_out <= pps_r[2][3:0]; // R8
    end
  end
  // ****************************************
  // Security and selection
  // ****************************************
  // Clear beats set: both clear on any reset, even with access_ok_in or a command in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || !contact_act_in || card_rst_pulse_in) begin
      secure_out <= 1'b0; // R11 R14
      selected_out <= 1'b0;
    end else begin
      if (access_ok_in) begin
        secure_out <= 1'b1;
        selected_out <= 1'b1; // R15
      end else if (no_access_cond_in && app_cmd_in && !status_cmd_in && !app_select_in) begin
        selected_out <= 1'b1; // R15
      end
    end
  end
  catr_pps_chk u_chk (
    .fi_in(pps_r[2][7:4]),
    .di_in(pps_r[2][3:0]),
    .ok_out(pps_ok)
  );
  assign pps_pck = pps_r[0] ^ pps_r[1] ^ pps_r[2];
  // ****************************************
  // Answer and PPS sequencer
  // ****************************************
  // The answer comes from constants only, so warm answers can never differ
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || !contact_act_in) begin
      state_r <= CATR_OFF;
      idx_r <= 5'h00;
      chk_r <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      atr_done_out <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        pps_r[k] <= 8'h00;
      end
    end else if (card_rst_pulse_in) begin
      state_r <= CATR_SEND_ATR; // R1
      idx_r <= 5'h01;
      chk_r <= 8'h00;
      tx_valid_out <= 1'b1;
      tx_byte_out <= catr_atr_byte(5'h00); // R13
      atr_done_out <= 1'b0;
    end else begin
      case (state_r)
        CATR_SEND_ATR: begin
          if (tx_ready_in) begin
            if (idx_r == CATR_ATR_LEN[4:0]) begin
              tx_valid_out <= 1'b0;
              atr_done_out <= 1'b1;
              state_r <= CATR_PPS_WAIT;
            end else begin
              // Check byte excludes TS and closes the string
              if (idx_r == CATR_ATR_LEN[4:0] - 5'h01) begin
                tx_byte_out <= chk_r ^ catr_atr_byte(idx_r - 5'h01);
              end else begin
                tx_byte_out <= catr_atr_byte(idx_r); // R3 R4 R5 R7
              end
              if (idx_r > 5'h01) begin
                chk_r <= chk_r ^ catr_atr_byte(idx_r - 5'h01);
              end
              idx_r <= idx_r + 5'h01;
            end
          end
        end
        CATR_PPS_WAIT: begin
          // Only a PPS start right after the answer opens negotiation
          if (rx_valid_in) begin
            state_r <= (rx_byte_in == CATR_PPSS && !specific_out) ? CATR_PPS_RX : CATR_RUN;
            pps_r[0] <= rx_byte_in;
            idx_r <= 5'h01;
          end
        end
        CATR_PPS_RX: begin
          if (rx_valid_in) begin
            pps_r[idx_r[1:0]] <= rx_byte_in;
            idx_r <= idx_r + 5'h01;
            if (idx_r == 5'h03) begin
              state_r <= CATR_PPS_ECHO;
              idx_r <= 5'h00;
              tx_valid_out <= 1'b1;
              tx_byte_out <= pps_r[0];
            end
          end
        end
        CATR_PPS_ECHO: begin
          // Echo the request when supported and consistent, else send PPSS then three zero bytes
          if (tx_ready_in) begin
            if (idx_r == 5'h03) begin
              tx_valid_out <= 1'b0;
              state_r <= CATR_RUN;
            end else begin
              idx_r <= idx_r + 5'h01;
              if (pps_ok && pps_pck == pps_r[3]) begin
                tx_byte_out <= pps_r[idx_r[1:0] + 2'h1];
              end else begin
                tx_byte_out <= 8'h00;
              end
            end
          end
        end
        CATR_RUN: begin
          tx_valid_out <= 1'b0;
        end
        default: begin
          state_r <= CATR_OFF;
        end
      endcase
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_atr_first: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R1
    card_rst_pulse_in && contact_act_in |=> tx_valid_out && tx_byte_out == CATR_TS_DIRECT)
    else $error("Answer does not open with TS");
  a_cold_mode: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R11
    card_rst_pulse_in && !session_r |=> !specific_out && !secure_out && fi_out == CATR_FI_372)
    else $error("Cold reset left non-negotiable state");
  a_warm_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R10
    card_rst_pulse_in && contact_act_in |=> warm_out == $past(session_r))
    else $error("Warm flag wrong");
  a_warm_secure: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R14
    card_rst_pulse_in |=> !secure_out && !selected_out)
    else $error("Security kept over reset");
  a_session_drop: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R19
    !contact_act_in |=> !session_r && state_r == CATR_OFF)
    else $error("Session not dropped");
  a_select_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R15
    access_ok_in && contact_act_in && !card_rst_pulse_in |=> selected_out)
    else $error("Selection not flagged");
  a_status_noset: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R15
    $rose(selected_out) |-> $past(access_ok_in) || ($past(app_cmd_in) && !$past(status_cmd_in)))
    else $error("Selection set without cause");
  a_factor_legal: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R6
    $changed(fi_out) && !$past(card_rst_pulse_in) |-> $past(pps_ok) && $past(state_r) == CATR_PPS_ECHO
      && $past(pps_pck) == $past(pps_r[3]))
    else $error("Factors changed outside PPS");
  a_type_one: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // R17
    card_rst_pulse_in |=> specific_out == CATR_TYPE2 && (!specific_out || warm_out))
    else $error("Reaction type broken");
  c_cold_atr: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $rose(atr_done_out) && !warm_out);
  c_warm_atr: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $rose(atr_done_out) && warm_out);
  c_pps_done: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $changed(di_out) && state_r == CATR_RUN);
  c_selected: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $rose(selected_out));
endmodule : catr_top

// >>> catr_term_model.sv
// Terminal-side model: drives contacts, reset and bytes, takes the bytes the card sends
`timescale 1ns/1ps
module catr_term_model (
  input wire logic sys_clk_in, // System clock
  input wire logic stall_in, // Hold off taking bytes
  input wire logic tx_valid_in, // Card offers a byte
  input wire logic [7:0] tx_byte_in, // Byte offered
  output logic contact_act_out, // Contacts active
  output logic card_rst_pulse_out, // Reset released pulse
  output logic rx_valid_out, // Byte strobe to card
  output logic [7:0] rx_byte_out, // Byte to card
  output logic tx_ready_out // Taking bytes
);
  logic [7:0] got_q[$]; // Bytes taken from the card
  // ****************************************
  // Drivers
  // ****************************************
  // Idle values at time zero
  initial begin
    contact_act_out = 1'b0;
    card_rst_pulse_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // Random stalls model a slow receiver
  always @(negedge sys_clk_in) tx_ready_out <= !stall_in;
  // Every byte is kept, whatever interface or historical byte it is
  always @(posedge sys_clk_in) if (tx_valid_in && tx_ready_out) got_q.push_back(tx_byte_in);
  // Contacts on or off
  task automatic set_contact(input logic on);
    @(negedge sys_clk_in);
    contact_act_out = on;
  endtask : set_contact
  // Reset pulse; the queue restarts so index 0 is the first byte after it
  task automatic reset_card();
    @(negedge sys_clk_in);
    got_q.delete();
    card_rst_pulse_out = 1'b1;
    @(negedge sys_clk_in);
    card_rst_pulse_out = 1'b0;
  endtask : reset_card
  // One byte; released data flips so a stale value is never mistaken for data
  task automatic send_byte(input logic [7:0] b);
    @(negedge sys_clk_in);
    rx_byte_out = b;
    rx_valid_out = 1'b1;
    @(negedge sys_clk_in);
    rx_byte_out = ~b;
    rx_valid_out = 1'b0;
  endtask : send_byte
endmodule : catr_term_model

// >>> test_catr_top.sv
// Self-checking testbench of the card answer-to-reset block
`timescale 1ns/1ps
module test_catr_top;
  import catr_pkg::*;
  logic sys_clk_in, rst_b_in, stall, tx_valid, warm, spec, secure, sel, done; // Clock, reset, flags
  logic access_ok, app_cmd, no_acc, status_cmd, app_sel, contact_act, rst_pulse, rx_valid, tx_ready; // Inputs
  logic [7:0] rx_byte, tx_byte; // Byte paths
  logic [3:0] fi, di; // Factors in force
  logic [31:0] seed = 32'h0000004f; // Xorshift state
  int n_mismatch = 0; // Mismatches
  int total_checks = 0; // Comparisons
  int cycles = 0; // Cycles run
  catr_term_model term_i (.sys_clk_in(sys_clk_in), .stall_in(stall), .tx_valid_in(tx_valid),
    .tx_byte_in(tx_byte), .contact_act_out(contact_act), .card_rst_pulse_out(rst_pulse),
    .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .tx_ready_out(tx_ready));
  catr_top catr_top_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .contact_act_in(contact_act),
    .card_rst_pulse_in(rst_pulse), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .tx_ready_in(tx_ready),
    .access_ok_in(access_ok), .app_cmd_in(app_cmd), .no_access_cond_in(no_acc), .status_cmd_in(status_cmd),
    .app_select_in(app_sel), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte), .fi_out(fi), .di_out(di),
    .warm_out(warm), .specific_out(spec), .secure_out(secure), .selected_out(sel), .atr_done_out(done));
  // ****************************************
  // Helpers
  // ****************************************
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Expected answer byte; mandated bytes are literals, check byte is the XOR of 1..15
  function automatic logic [7:0] exp_atr(input int i);
    logic [7:0] t[17];
    t = '{8'h3b, CATR_T0_BYTE, CATR_TA1_BYTE, CATR_TD1_BYTE, 8'h1f, CATR_TA3_BYTE, 8'h80, 8'h31,
      CATR_CDS_VAL, 8'h73, CATR_CCAP_VAL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 1; k < 16; k++) t[16] = t[16] ^ t[k];
    return t[i];
  endfunction : exp_atr
  // Byte compare
  task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
    total_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t byte %h expected %h", $time, a, e);
    end
  endtask : chk_byte
  // Flag compare
  task automatic chk_flag(input logic a, input logic e);
    chk_byte({7'h00, a}, {7'h00, e});
  endtask : chk_flag
  // Bounded wait for n bytes taken by the terminal
  task automatic wait_bytes(input int n);
    for (int k = 0; k < 400 && term_i.got_q.size() < n; k++) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    if (term_i.got_q.size() < n) chk_flag(1'b0, 1'b1);
  endtask : wait_bytes
  // Reset the card and compare the whole answer
  task automatic get_atr(input logic exp_warm);
    term_i.reset_card();
    wait_bytes(17);
    for (int i = 0; i < 17; i++) chk_byte(term_i.got_q[i], exp_atr(i));
    @(negedge sys_clk_in);
    chk_flag(done, 1'b1);
    chk_flag(warm, exp_warm);
    chk_flag(secure, 1'b0);
    chk_flag(spec, 1'b0);
    chk_byte({fi, di}, 8'h11);
  endtask : get_atr
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // ****************************************
  // Clock, stalls, timeout
  // ****************************************
  // Clock of 10 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Random stall drawn at the rising edge, applied by the model at the falling edge
  always @(posedge sys_clk_in) begin
    seed = xs(seed);
    stall <= seed[0] & seed[1];
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [3:0] pf[4];
    logic [3:0] pd[4];
    logic [7:0] pck;
    pf = '{4'h9, 4'h9, 4'h1, 4'h9};
    pd = '{4'h4, 4'h5, 4'h4, 4'h5};
    {rst_b_in, access_ok, app_cmd, no_acc, status_cmd, app_sel} = 6'h00;
    repeat (5) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    term_i.set_contact(1'b1);
    get_atr(1'b0);
    // Status with a command does not select; a lone command or a verify does
    no_acc = 1'b1;
    @(negedge sys_clk_in);
    {status_cmd, app_cmd} = 2'b11;
    @(negedge sys_clk_in);
    {status_cmd, app_cmd} = 2'b00;
    @(negedge sys_clk_in);
    chk_flag(sel, 1'b0);
    // Select issued together with a command does not count either
    {app_sel, app_cmd} = 2'b11;
    @(negedge sys_clk_in);
    {app_sel, app_cmd} = 2'b00;
    @(negedge sys_clk_in);
    chk_flag(sel, 1'b0);
    app_cmd = 1'b1;
    @(negedge sys_clk_in);
    {app_cmd, access_ok} = 2'b01;
    @(negedge sys_clk_in);
    access_ok = 1'b0;
    @(negedge sys_clk_in);
    chk_flag(sel, 1'b1);
    chk_flag(secure, 1'b1);
    $display("test cold and select done");
    // Warm resets, each followed by one PPS; then an unsupported pair, then a bad check byte
    for (int i = 0; i < 4; i++) begin
      get_atr(1'b1);
      pck = 8'hff ^ 8'h10 ^ {pf[i], pd[i]} ^ ((i == 3) ? 8'h01 : 8'h00);
      term_i.send_byte(8'hff);
      term_i.send_byte(8'h10);
      term_i.send_byte({pf[i], pd[i]});
      term_i.send_byte(pck);
      wait_bytes(21);
      repeat (2) @(negedge sys_clk_in);
      chk_byte(term_i.got_q[17], 8'hff);
      chk_byte(term_i.got_q[18], (i < 2) ? 8'h10 : 8'h00);
      chk_byte(term_i.got_q[19], (i < 2) ? {pf[i], pd[i]} : 8'h00);
      chk_byte(term_i.got_q[20], (i < 2) ? pck : 8'h00);
      chk_byte({fi, di}, (i < 2) ? {pf[i], pd[i]} : 8'h11);
      $display("test pps pair %0d done", i);
    end
    // New session: first reset is cold again
    term_i.set_contact(1'b0);
    repeat (3) @(negedge sys_clk_in);
    term_i.set_contact(1'b1);
    get_atr(1'b0);
    $display("test new session done");
    final_report();
  end
endmodule : test_catr_top
